// ---- inc/ecp_pkg.sv ----
package ecp_pkg;
  localparam int unsigned PWORD_W  = 8;
  localparam int unsigned FIFO_DEP = 16;
  localparam int unsigned FIFO_AW  = 4;
  localparam int unsigned CNT_W    = 5;
  // Register indices; byte address is four times the index
  localparam logic [10:0] IDX_DATA = 11'h000;
  localparam logic [10:0] IDX_DSR  = 11'h001;
  localparam logic [10:0] IDX_DCR  = 11'h002;
  localparam logic [10:0] IDX_FIFO = 11'h400;
  localparam logic [10:0] IDX_CFGB = 11'h401;
  localparam logic [10:0] IDX_ECR  = 11'h402;
  // Control register fields
  localparam int unsigned DCR_STROBE = 0;
  localparam int unsigned DCR_AUTOFD = 1;
  localparam int unsigned DCR_NINIT  = 2;
  localparam int unsigned DCR_SELIN  = 3;
  localparam int unsigned DCR_DIR    = 5;
  localparam logic [5:0]  DCR_RST    = 6'h00;
  // Extended control fields
  localparam int unsigned ECR_MODE_LSB = 5;
  localparam int unsigned ECR_ERRMASK  = 4;
  localparam int unsigned ECR_DMA_REQUEST_ENABLE    = 3;
  localparam int unsigned ECR_SVC      = 2;
  localparam logic        ERRMASK_RST  = 1'b1;
  localparam logic        SVC_RST      = 1'b1;
  localparam logic [7:0]  CAPABILITY_WORD_A_VAL    = 8'h10;
  localparam logic        CMP_SUPPORT  = 1'b0;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [CNT_W-1:0] SVC_THRESH = 5'h08;
  localparam int unsigned RLE_ADDR_BIT = 7;
  // Compatibility strobe width and data setup
  localparam int unsigned CLK_NS   = 5;
  localparam int unsigned STB_NS   = 500;
  localparam int unsigned SETUP_NS = 500;
  localparam int unsigned STB_CYC  = (STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SET_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TCNT_W   = 7;

  typedef enum logic [2:0] {
    MODE_SPP   = 3'b000,
    MODE_PS2   = 3'b001,
    MODE_COMPAT_FIFO_PORT = 3'b010,
    MODE_ECP   = 3'b011,
    MODE_EPP   = 3'b100,
    MODE_RSVD  = 3'b101,
    MODE_TEST  = 3'b110,
    MODE_CNFG  = 3'b111
  } ecp_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_FWD_SETUP = 4'b0001,
    ST_FWD_STB   = 4'b0010,
    ST_FWD_REL   = 4'b0011,
    ST_REV_TURN  = 4'b0100,
    ST_FWD_TURN  = 4'b0101,
    ST_REV_REQ   = 4'b0110,
    ST_REV_ACK   = 4'b0111,
    ST_RLE_FILL  = 4'b1000
  } ecp_state_t;

  typedef struct packed {
    logic               tag;
    logic [PWORD_W-1:0] data;
  } ecp_word_t;

  typedef struct packed {
    logic [PWORD_W-1:0] pd;
    logic               nack;
    logic               busy;
    logic               perror;
    logic               select;
    logic               nfault;
  } ecp_pin_in_t;
endpackage

// ---- design/ecp_parallel_port_core.sv ----
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ecp_parallel_port_core (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [12:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Configuration and system
  input  wire logic [2:0]  i_cfg_irq_sel,
  input  wire logic [2:0]  i_cfg_dma_sel,
  input  wire logic        i_irq_level,
  output logic             o_dma_req,
  output logic             o_periph_req_err,
  // Parallel port pins
  input  wire logic [7:0]  i_pd,
  output logic      [7:0]  o_pd,
  output logic             o_pd_oe_n,
  output logic             o_nstrobe,
  output logic             o_nautofd,
  output logic             o_ninit,
  output logic             o_nselectin,
  input  wire logic        i_nack,
  input  wire logic        i_busy,
  input  wire logic        i_perror,
  input  wire logic        i_select,
  input  wire logic        i_nfault
);

  ecp_pkg::ecp_pin_in_t  sync1_ff;
  ecp_pkg::ecp_pin_in_t  sync2_ff;
  ecp_pkg::ecp_mode_t    mode_ff;
  ecp_pkg::ecp_state_t   state_ff;
  ecp_pkg::ecp_word_t    mem [ecp_pkg::FIFO_DEP];
  ecp_pkg::ecp_word_t    out_word_ff;
  ecp_pkg::ecp_word_t    push_word;
  ecp_pkg::ecp_word_t    head_word;
  logic [7:0]                 data_ff;
  logic [5:0]                 dcr_ff;
  logic                       err_mask_ff;
  logic                       dma_en_ff;
  logic                       svc_ff;
  logic [ecp_pkg::FIFO_AW-1:0] wr_ptr_ff;
  logic [ecp_pkg::FIFO_AW-1:0] rd_ptr_ff;
  logic [ecp_pkg::CNT_W-1:0]   count_ff;
  logic [7:0]                 last_rd_ff;
  logic                       pready_ff;
  logic                       pslverr_ff;
  logic [31:0]                prdata_ff;
  logic [ecp_pkg::TCNT_W-1:0] tcnt_ff;
  logic                       rev_dir_ff;
  logic [6:0]                 rle_cnt_ff;
  logic                       rle_pend_ff;
  logic                       rle_go_ff;
  logic [7:0]                 rev_byte_ff;
  logic [7:0]                 pd_ff;
  logic                       pd_oe_n_ff;
  logic                       nstrobe_ff;
  logic                       nautofd_ff;
  logic                       ninit_ff;
  logic                       nselin_ff;
  logic [7:0]                 nxt_pd;
  logic                       nxt_pd_oe_n;
  logic                       nxt_nstrobe;
  logic                       nxt_nautofd;
  logic                       nxt_ninit;
  logic                       nxt_nselin;
  logic [10:0]                idx;
  logic                       setup;
  logic                       done;
  logic                       mapped;
  logic [7:0]                 rdval;
  logic                       wr_ok;
  logic                       rd_ok;
  logic                       full;
  logic                       empty;
  logic                       eff_dir;
  logic                       is_ecp;
  logic                       is_compat_fifo_port;
  logic                       fifo_mode;
  logic                       host_push;
  logic                       host_pop;
  logic                       eng_push;
  logic                       eng_pop;
  logic                       push;
  logic                       pop;
  logic                       flush;
  logic                       svc_set;
  logic                       rev_cmd;

  // Pins cross into the clock domain through two flops
  always_ff @(posedge i_clk) begin
    sync1_ff <= {i_pd, i_nack, i_busy, i_perror, i_select, i_nfault};
    sync2_ff <= sync1_ff;
  end

  assign is_ecp    = (mode_ff == ecp_pkg::MODE_ECP);
  assign is_compat_fifo_port  = (mode_ff == ecp_pkg::MODE_COMPAT_FIFO_PORT);
  assign fifo_mode = is_ecp | is_compat_fifo_port;
  // Modes 000 and 010 force the port to output
  assign eff_dir = ((mode_ff == ecp_pkg::MODE_SPP) | is_compat_fifo_port) ? 1'b0 : dcr_ff[ecp_pkg::DCR_DIR];
  assign full  = (count_ff == ecp_pkg::CNT_W'(ecp_pkg::FIFO_DEP));
  assign empty = (count_ff == '0);
  assign head_word = mem[rd_ptr_ff];

  // APB decode; one wait-free access phase after setup
  assign setup = i_psel & ~i_penable;
  assign done  = i_psel & i_penable & pready_ff;
  assign idx   = i_paddr[12:2];

  always_comb begin
    mapped = 1'b1;
    rdval  = 8'h00;
    case (idx)
      ecp_pkg::IDX_DATA: begin
        mapped = (mode_ff == ecp_pkg::MODE_SPP) | (mode_ff == ecp_pkg::MODE_PS2) | is_ecp;
        rdval  = is_ecp ? 8'h00 : sync2_ff.pd;
      end
      ecp_pkg::IDX_DSR: begin
        rdval = {~sync2_ff.busy, sync2_ff.nack, sync2_ff.perror,
                 sync2_ff.select, sync2_ff.nfault, 3'b000};
      end
      ecp_pkg::IDX_DCR: begin
        rdval = {2'b00, dcr_ff};
      end
      ecp_pkg::IDX_FIFO: begin
        mapped = fifo_mode | (mode_ff == ecp_pkg::MODE_TEST) | (mode_ff == ecp_pkg::MODE_CNFG);
        if (mode_ff == ecp_pkg::MODE_CNFG) begin
          rdval = ecp_pkg::CAPABILITY_WORD_A_VAL;
        end else begin
          rdval = empty ? last_rd_ff : head_word.data;
        end
      end
      ecp_pkg::IDX_CFGB: begin
        mapped = (mode_ff == ecp_pkg::MODE_CNFG);
        rdval  = {ecp_pkg::CMP_SUPPORT, i_irq_level, i_cfg_irq_sel, i_cfg_dma_sel};
      end
      ecp_pkg::IDX_ECR: begin
        rdval = {mode_ff, err_mask_ff, dma_en_ff, svc_ff, full, empty};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (setup) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= ~mapped;
      prdata_ff  <= {24'h00_0000, rdval};
    end else if (done) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign wr_ok = done & i_pwrite & mapped;
  assign rd_ok = done & ~i_pwrite & mapped;

  // Host side of the shared FIFO
  always_comb begin
    host_push = 1'b0;
    push_word = '0;
    if (wr_ok & ~full) begin
      if (idx == ecp_pkg::IDX_FIFO) begin
        host_push = is_compat_fifo_port | (is_ecp & ~eff_dir) | (mode_ff == ecp_pkg::MODE_TEST);
      end else if (idx == ecp_pkg::IDX_DATA) begin
        host_push = is_ecp & ~eff_dir;
        push_word.tag = 1'b1;
      end
    end
    push_word.data = host_push ? i_pwdata[7:0] : (rle_go_ff ? rev_byte_ff : sync2_ff.pd);
  end

  assign host_pop = rd_ok & ~empty & (idx == ecp_pkg::IDX_FIFO) &
                    ((is_ecp & eff_dir) | (mode_ff == ecp_pkg::MODE_TEST));
  assign flush = wr_ok & (idx == ecp_pkg::IDX_ECR) & (i_pwdata[7:6] == 2'b00);
  assign rev_cmd = ~sync2_ff.busy;

  // Engine side: a plain reverse data byte, or run-length fill
  assign eng_push = ((state_ff == ecp_pkg::ST_REV_REQ) & ~sync2_ff.nack & ~rev_cmd & ~rle_pend_ff)
                  | ((state_ff == ecp_pkg::ST_RLE_FILL) & ~full);
  assign eng_pop  = (state_ff == ecp_pkg::ST_IDLE) & ~empty & ~rev_dir_ff &
                    (is_compat_fifo_port | (is_ecp & ~eff_dir));
  assign push = host_push | eng_push;
  assign pop  = host_pop | eng_pop;

  // Single buffer behind every FIFO view, both directions
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= push_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + ecp_pkg::CNT_W'(push) - ecp_pkg::CNT_W'(pop);
    end
  end

  // Empty test FIFO reads repeat the last byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      last_rd_ff <= 8'h00;
    end else if (host_pop) begin
      last_rd_ff <= head_word.data;
    end
  end

  // Software registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      data_ff <= ecp_pkg::DATA_RST;
      dcr_ff  <= ecp_pkg::DCR_RST;
    end else if (wr_ok) begin
      if (idx == ecp_pkg::IDX_DATA && !is_ecp) begin
        data_ff <= i_pwdata[7:0];
      end
      if (idx == ecp_pkg::IDX_DCR) begin
        dcr_ff <= i_pwdata[5:0];
      end
    end
  end

  // Threshold: eight free slots forward, eight held reverse
  assign svc_set = fifo_mode & ~dma_en_ff &
                   (eff_dir ? (count_ff >= ecp_pkg::SVC_THRESH) : (count_ff <= ecp_pkg::SVC_THRESH));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_ff     <= ecp_pkg::MODE_SPP;
      err_mask_ff <= ecp_pkg::ERRMASK_RST;
      dma_en_ff   <= 1'b0;
      svc_ff      <= ecp_pkg::SVC_RST;
    end else begin
      if (wr_ok && idx == ecp_pkg::IDX_ECR) begin
        mode_ff     <= ecp_pkg::ecp_mode_t'(i_pwdata[ecp_pkg::ECR_MODE_LSB +: 3]);
        err_mask_ff <= i_pwdata[ecp_pkg::ECR_ERRMASK];
        dma_en_ff   <= i_pwdata[ecp_pkg::ECR_DMA_REQUEST_ENABLE];
      end
      // Hardware set beats a software clear in the same cycle
      if (svc_set) begin
        svc_ff <= 1'b1;
      end else if (wr_ok && idx == ecp_pkg::IDX_ECR) begin
        svc_ff <= i_pwdata[ecp_pkg::ECR_SVC];
      end
    end
  end

  // DMA request towards the host; no negotiation in hardware
  assign o_dma_req = fifo_mode & dma_en_ff & ~svc_ff & (eff_dir ? ~empty : ~full);
  // Peer hint only; direction stays under software control
  assign o_periph_req_err = is_ecp & ~rev_dir_ff & ~sync2_ff.nfault & ~err_mask_ff;

  // Transfer engine; turnaround only between bytes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || flush) begin
      state_ff    <= ecp_pkg::ST_IDLE;
      tcnt_ff     <= '0;
      out_word_ff <= '0;
      rev_dir_ff  <= 1'b0;
      rle_cnt_ff  <= 7'h00;
      rle_pend_ff <= 1'b0;
      rle_go_ff   <= 1'b0;
      rev_byte_ff <= 8'h00;
    end else if (!fifo_mode) begin
      state_ff <= ecp_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        ecp_pkg::ST_IDLE: begin
          tcnt_ff <= '0;
          if (is_ecp && eff_dir != rev_dir_ff) begin
            state_ff <= eff_dir ? ecp_pkg::ST_REV_TURN : ecp_pkg::ST_FWD_TURN;
          end else if (eng_pop) begin
            out_word_ff <= head_word;
            state_ff    <= ecp_pkg::ST_FWD_SETUP;
          end else if (is_ecp && rev_dir_ff && !full) begin
            state_ff <= ecp_pkg::ST_REV_REQ;
          end
        end
        ecp_pkg::ST_FWD_SETUP: begin
          // Data settles before the strobe edge
          if (tcnt_ff != ecp_pkg::TCNT_W'(ecp_pkg::SET_CYC - 1)) begin
            tcnt_ff <= tcnt_ff + 1'b1;
          end else if (!sync2_ff.busy) begin
            tcnt_ff  <= '0;
            state_ff <= ecp_pkg::ST_FWD_STB;
          end
        end
        ecp_pkg::ST_FWD_STB: begin
          if (is_compat_fifo_port) begin
            tcnt_ff <= tcnt_ff + 1'b1;
            if (tcnt_ff == ecp_pkg::TCNT_W'(ecp_pkg::STB_CYC - 1)) begin
              state_ff <= ecp_pkg::ST_FWD_REL;
            end
          end else if (sync2_ff.busy) begin
            state_ff <= ecp_pkg::ST_FWD_REL;
          end
        end
        ecp_pkg::ST_FWD_REL: begin
          if (!sync2_ff.busy) begin
            state_ff <= ecp_pkg::ST_IDLE;
          end
        end
        ecp_pkg::ST_REV_TURN: begin
          if (!sync2_ff.perror) begin
            rev_dir_ff <= 1'b1;
            state_ff   <= ecp_pkg::ST_IDLE;
          end
        end
        ecp_pkg::ST_FWD_TURN: begin
          if (sync2_ff.perror) begin
            rev_dir_ff <= 1'b0;
            state_ff   <= ecp_pkg::ST_IDLE;
          end
        end
        ecp_pkg::ST_REV_REQ: begin
          if (!sync2_ff.nack) begin
            state_ff <= ecp_pkg::ST_REV_ACK;
            if (rev_cmd) begin
              // Channel addresses are dropped; counts arm the expander
              if (!sync2_ff.pd[ecp_pkg::RLE_ADDR_BIT]) begin
                rle_cnt_ff  <= sync2_ff.pd[6:0];
                rle_pend_ff <= 1'b1;
              end
            end else if (rle_pend_ff) begin
              rev_byte_ff <= sync2_ff.pd;
              rle_pend_ff <= 1'b0;
              rle_go_ff   <= 1'b1;
            end
          end else if (!eff_dir) begin
            // Turned forward with no byte offered; otherwise the engine waits forever
            state_ff <= ecp_pkg::ST_IDLE;
          end
        end
        ecp_pkg::ST_REV_ACK: begin
          if (sync2_ff.nack) begin
            state_ff <= rle_go_ff ? ecp_pkg::ST_RLE_FILL : ecp_pkg::ST_IDLE;
          end
        end
        ecp_pkg::ST_RLE_FILL: begin
          // Count n gives n+1 copies; stalls while the FIFO is full
          if (eng_push) begin
            rle_cnt_ff <= rle_cnt_ff - 1'b1;
            if (rle_cnt_ff == 7'h00) begin
              rle_go_ff <= 1'b0;
              state_ff  <= ecp_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ecp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pin values; legacy register view unless a FIFO mode owns the lines
  always_comb begin
    nxt_pd      = data_ff;
    nxt_pd_oe_n = eff_dir;
    nxt_nstrobe = ~dcr_ff[ecp_pkg::DCR_STROBE];
    nxt_nautofd = ~dcr_ff[ecp_pkg::DCR_AUTOFD];
    nxt_ninit   = dcr_ff[ecp_pkg::DCR_NINIT];
    nxt_nselin  = ~dcr_ff[ecp_pkg::DCR_SELIN];
    if (fifo_mode) begin
      nxt_pd      = out_word_ff.data;
      nxt_nstrobe = (state_ff != ecp_pkg::ST_FWD_STB);
    end
    if (is_ecp) begin
      nxt_nselin = 1'b1;
      nxt_ninit  = (state_ff == ecp_pkg::ST_FWD_TURN) |
                   ~(rev_dir_ff | (state_ff == ecp_pkg::ST_REV_TURN));
      // Data lines stay released until nAckReverse confirms forward
      nxt_pd_oe_n = eff_dir | rev_dir_ff | (state_ff == ecp_pkg::ST_REV_TURN);
      if (rev_dir_ff) begin
        nxt_nautofd = (state_ff != ecp_pkg::ST_REV_REQ);
      end else begin
        nxt_nautofd = ~out_word_ff.tag;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pd_ff      <= 8'h00;
      pd_oe_n_ff <= 1'b0;
      nstrobe_ff <= 1'b1;
      nautofd_ff <= 1'b1;
      ninit_ff   <= 1'b0;
      nselin_ff  <= 1'b1;
    end else begin
      pd_ff      <= nxt_pd;
      pd_oe_n_ff <= nxt_pd_oe_n;
      nstrobe_ff <= nxt_nstrobe;
      nautofd_ff <= nxt_nautofd;
      ninit_ff   <= nxt_ninit;
      nselin_ff  <= nxt_nselin;
    end
  end

  assign o_prdata    = prdata_ff;
  assign o_pready    = pready_ff;
  assign o_pslverr   = pslverr_ff;
  assign o_pd        = pd_ff;
  assign o_pd_oe_n   = pd_oe_n_ff;
  assign o_nstrobe   = nstrobe_ff;
  assign o_nautofd   = nautofd_ff;
  assign o_ninit     = ninit_ff;
  assign o_nselectin = nselin_ff;

endmodule
`default_nettype wire

// ---- verification/ecp_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_monitor (
  // Bus
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [12:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  // Pins and events
  input wire logic        o_pd_oe_n,
  input wire logic        o_nstrobe,
  input wire logic        o_ninit,
  input wire logic        o_nselectin,
  input wire logic        i_busy,
  input wire logic        i_perror,
  input wire logic        i_nfault,
  input wire logic        o_dma_req,
  input wire logic        o_periph_req_err
);
  logic [2:0] mode_ff;
  logic       was_ecp_ff;
  wire        ecp2;
  // Mode is shadowed from completed writes; a mode switch is given one cycle to settle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_ff <= 3'h0;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr[12:2] == 11'h402) begin
      mode_ff <= i_pwdata[7:5];
    end
  end
  always_ff @(posedge i_clk) begin
    was_ecp_ff <= i_rst_n && mode_ff == 3'h3;
  end
  assign ecp2 = mode_ff == 3'h3 && was_ecp_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sel_ecp_a: assert property (ecp2 |-> o_nselectin)
    else $error("select line active in burst mode");
  rdy_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h00_0000)
    else $error("read data wider than a port word");
  rev_float_a: assert property (ecp2 && !o_ninit |-> o_pd_oe_n)
    else $error("data pins driven in reverse");
  drive_ok_a: assert property (ecp2 && $fell(o_pd_oe_n)
    |-> $past(i_perror, 2) && $past(i_perror, 3)) else $error("drive before turnaround ack");
  stb_lock_a: assert property (ecp2 && $rose(o_nstrobe) |-> $past(i_busy, 2))
    else $error("strobe released before busy");
  dma_mode_a: assert property (o_dma_req |-> mode_ff inside {3'h2, 3'h3})
    else $error("dma request outside fifo modes");
  err_src_a: assert property (o_periph_req_err
    |-> mode_ff == 3'h3 && !($past(i_nfault, 2) && $past(i_nfault, 3))) else $error("bad error event");
endmodule
bind ecp_parallel_port_core ecp_monitor i_ecp_monitor (.i_clk, .i_rst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pd_oe_n, .o_nstrobe, .o_ninit,
  .o_nselectin, .i_busy, .i_perror, .i_nfault, .o_dma_req, .o_periph_req_err);
`default_nettype wire

// ---- verification/ecp_peer_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_peer_model (
  // From host
  input  wire logic       i_clk,
  input  wire logic [7:0] i_pd,
  input  wire logic       i_nstrobe,
  input  wire logic       i_nautofd,
  input  wire logic       i_ninit,
  input  wire logic       i_nselectin,
  // To host
  output logic      [7:0] o_pd,
  output logic            o_nack,
  output logic            o_busy,
  output logic            o_perror,
  output logic            o_select,
  output logic            o_nfault
);
  logic [8:0] fwd_q[$];
  logic [8:0] rev_q[$];
  logic       fault_req = 1'b0;
  logic       rdy = 1'b0;
  int         slow = 0;
  int         wt = 0;
  assign o_select = 1'b1;
  assign o_nfault = !fault_req;
  initial begin
    {o_pd, o_nack, o_busy, o_perror} = {8'hFF, 3'b101};
  end
  always @(posedge i_clk) begin
    if (i_ninit) begin
      {o_perror, o_nack, rdy} <= 3'b110;
      if (!i_nstrobe && !o_busy) begin
        fwd_q.push_back({i_nautofd, i_pd});
        o_busy <= 1'b1;
      end else if (i_nstrobe && o_busy) begin
        // Slow peers hold busy longer to stress the interlock
        wt <= (wt >= slow) ? 0 : wt + 1;
        o_busy <= (wt < slow);
      end
    end else begin
      o_perror <= 1'b0;
      if (i_nautofd || !i_nselectin) begin
        if (rdy) begin
          // Released lines show the inverse, never the stale byte
          o_pd <= ~o_pd;
          void'(rev_q.pop_front());
        end
        {o_nack, rdy} <= 2'b10;
      end else if (rev_q.size() > 0) begin
        {o_busy, o_pd} <= rev_q[0];
        o_nack <= !rdy;
        rdy <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/ecp_parallel_port_core_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_parallel_port_core_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, re;
  logic [12:0] padr = 13'h0000;
  logic [31:0] pwd = 32'h0000_0000, prd;
  logic        prdy, perr, dma, perq, oe_n, nstb, nafd, nini, nsel, nack, busy, pe, sel, nflt;
  logic [7:0]  pd_o, pd_p, rv;
  logic [7:0]  rexp [5] = '{8'hA5, 8'h3C, 8'h3C, 8'h3C, 8'h11};
  wire  [7:0]  pd_in;
  int          err_total = 0, total_checks = 0;
  assign pd_in = !oe_n ? pd_o : pd_p;
  always #2.5 clk = ~clk;
  ecp_parallel_port_core i_ecp_parallel_port_core (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_cfg_irq_sel(3'h5), .i_cfg_dma_sel(3'h3), .i_irq_level(1'b1), .o_dma_req(dma),
    .o_periph_req_err(perq), .i_pd(pd_in), .o_pd(pd_o), .o_pd_oe_n(oe_n), .o_nstrobe(nstb),
    .o_nautofd(nafd), .o_ninit(nini), .o_nselectin(nsel), .i_nack(nack), .i_busy(busy),
    .i_perror(pe), .i_select(sel), .i_nfault(nflt));
  ecp_peer_model i_ecp_peer_model (
    .i_clk(clk), .i_pd(pd_in), .i_nstrobe(nstb), .i_nautofd(nafd), .i_ninit(nini),
    .i_nselectin(nsel), .o_pd(pd_p), .o_nack(nack), .o_busy(busy), .o_perror(pe),
    .o_select(sel), .o_nfault(nflt));
  task chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task ax(input logic w, input logic [12:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    {psel, pen, pwr, padr, pwd} <= {2'b10, w, a, 24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // Bounded so a dead slave cannot hang the run
    for (n = 0; prdy !== 1'b1 && n < 50; n++) @(posedge clk);
    if (n == 50) err_total++;
    {rv, re} = {prd[7:0], perr};
    {psel, pen} <= 2'b00;
  endtask
  task rd(input logic [12:0] a, input logic [8:0] e);
    ax(1'b0, a, 8'h00);
    chk({re, rv}, e);
  endtask
  task wq(input int n);
    for (int k = 0; i_ecp_peer_model.fwd_q.size() < n && k < 9000; k++) @(posedge clk);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({nstb, nsel, nini}, 3'b110);
    rd(13'h1008, 8'h15);
    // nInit is low after reset, so the peer holds nAckReverse low
    rd(13'h0004, 8'hD8);
    ax(1'b1, 13'h0008, 8'hFF);
    rd(13'h0008, 8'h3F);
    chk({nstb, nafd, nini, nsel, oe_n}, 5'b00100);
    ax(1'b1, 13'h0000, 8'h5A);
    repeat (4) @(posedge clk);
    rd(13'h0000, 8'h5A);
    ax(1'b1, 13'h0008, 8'h04);
    ax(1'b1, 13'h1008, 8'hF0);
    rd(13'h1000, 8'h10);
    rd(13'h1004, 8'h6B);
    ax(1'b0, 13'h0010, 8'h00);
    chk(re, 1'b1);
    ax(1'b1, 13'h1008, 8'hD0);
    for (int i = 0; i < 17; i++) ax(1'b1, 13'h1000, 8'h30 + i[7:0]);
    ax(1'b0, 13'h1008, 8'h00);
    chk(rv[1:0], 2'b10);
    for (int i = 0; i < 17; i++) rd(13'h1000, 8'h30 + (i < 16 ? i[7:0] : 8'h0F));
    ax(1'b1, 13'h1008, 8'h00);
    ax(1'b1, 13'h1008, 8'h40);
    // Legacy strobe from the control register latched one byte in the peer
    chk(i_ecp_peer_model.fwd_q[0], 9'h000);
    i_ecp_peer_model.fwd_q.delete();
    i_ecp_peer_model.slow <= 5;
    ax(1'b1, 13'h1000, 8'hC3);
    ax(1'b1, 13'h1000, 8'h3C);
    wq(2);
    chk(i_ecp_peer_model.fwd_q[0][7:0], 8'hC3);
    chk(i_ecp_peer_model.fwd_q[1][7:0], 8'h3C);
    ax(1'b1, 13'h1008, 8'h00);
    i_ecp_peer_model.fwd_q.delete();
    ax(1'b1, 13'h1008, 8'h60);
    ax(1'b1, 13'h0000, 8'h82);
    ax(1'b1, 13'h1000, 8'h11);
    ax(1'b1, 13'h1000, 8'h22);
    wq(3);
    chk(i_ecp_peer_model.fwd_q[0], 9'h082);
    chk(i_ecp_peer_model.fwd_q[1], 9'h111);
    chk(i_ecp_peer_model.fwd_q[2], 9'h122);
    chk(nsel, 1'b1);
    i_ecp_peer_model.fault_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk(perq, 1'b1);
    i_ecp_peer_model.fault_req <= 1'b0;
    repeat (4) @(posedge clk);
    chk(perq, 1'b0);
    // First write cannot clear the service flag (set wins); second clears it
    ax(1'b1, 13'h1008, 8'h68);
    ax(1'b1, 13'h1008, 8'h68);
    repeat (2) @(posedge clk);
    chk(dma, 1'b1);
    ax(1'b1, 13'h1008, 8'h60);
    i_ecp_peer_model.rev_q = '{9'h1A5, 9'h002, 9'h13C, 9'h085, 9'h111};
    ax(1'b1, 13'h0008, 8'h24);
    for (int k = 0; i_ecp_peer_model.rev_q.size() > 0 && k < 5000; k++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk({nini, oe_n}, 2'b01);
    foreach (rexp[i]) rd(13'h1000, rexp[i]);
    ax(1'b1, 13'h0008, 8'h04);
    repeat (40) @(posedge clk);
    chk({nini, oe_n}, 2'b10);
    give_verdict();
  end
endmodule
`default_nettype wire
